// ---- csx_map.svh ----
// Offsets, field positions, reset values and timing counts of the serial engine.
// Assumes inclusion by csx_pkg.sv and csx_top.sv; definitions only.
`ifndef CSX_MAP_SVH
`define CSX_MAP_SVH

// Register offsets on the plain register port
`define CSX_OFS_CTL0     3'h0
`define CSX_OFS_CTL1     3'h1
`define CSX_OFS_CTL2     3'h2
`define CSX_OFS_STATUS   3'h3
`define CSX_OFS_TXBUF    3'h4
`define CSX_OFS_RXBUF    3'h5

// ctrl_reg_zero fields
`define CSX_C0_PWR       7
`define CSX_C0_TXE       6
`define CSX_C0_RXE       5
`define CSX_C0_DIR       4
`define CSX_C0_CONT      1
`define CSX_C0_SCE       0

// ctrl_reg_one fields
`define CSX_C1_CKP       4
`define CSX_C1_DAP       3
`define CSX_C1_CKS_HI    2
`define CSX_C1_CKS_LO    0
`define CSX_CKS_EXT      3'h7

// ctrl_reg_two field width and the full word length
`define CSX_C2_LEN_HI    3
`define CSX_LEN_ZERO     4'h0
`define CSX_LEN_FULL     4'h8

// serial_status_reg fields
`define CSX_ST_TSF       7
`define CSX_ST_OVE       0

// Reset values
`define CSX_RST_CTL0     8'h00
`define CSX_RST_CTL1     8'h00
`define CSX_RST_CTL2     4'h0
`define CSX_RST_BYTE     8'h00

// Internal shift clock is the peripheral clock divided by eight
`define CSX_FXX_DIV      8
`define CSX_HALF_CYC     (`CSX_FXX_DIV / 2)
`define CSX_DIV_W        3

`endif

// ---- csx_pkg.sv ----
// Types shared by the serial engine and its helpers.
// Assumes csx_map.svh is on the include path.
`include "csx_map.svh"

package csx_pkg;

  typedef enum logic {
    CSX_IDLE,
    CSX_RUN
  } csx_phase_e;

  // Register port request from the CPU side
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csx_req_s;

  // Interrupt request pulses
  typedef struct packed {
    logic te;
    logic rc;
    logic er;
  } csx_irq_s;

  // Whole state of the engine
  typedef struct packed {
    csx_phase_e  phase;
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [3:0]  ctl2;
    logic        tsf;
    logic        ove;
    logic [7:0]  tx_buf;
    logic        tx_full;
    logic [7:0]  rx_buf;
    logic        rx_unread;
    logic [7:0]  sreg;
    logic [3:0]  cnt;
    logic        sck;
    logic        sck_oe_n;
    logic        so;
    logic        sck_prev;
    csx_irq_s    irq;
    logic [7:0]  rd_data;
  } csx_state_s;

endpackage : csx_pkg

// ---- csx_sync.sv ----
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are quasi-static relative to the clock period.
module csx_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Level in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Only the second stage is visible to any logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : csx_sync

// ---- csx_clkdiv.sv ----
// Half-period tick generator for the internal shift clock.
// Assumes run is held high for the whole of a master transfer.
`include "csx_map.svh"

module csx_clkdiv (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control and tick
  input  wire logic run,
  output logic      tick
);

  localparam logic [`CSX_DIV_W-1:0] LAST = `CSX_DIV_W'(`CSX_HALF_CYC - 1);

  logic [`CSX_DIV_W-1:0] cnt_ff;
  logic                  tick_ff;

  // Restarts from zero each time run rises, so the first edge is a full half period away
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (cnt_ff == LAST);
      cnt_ff  <= (cnt_ff == LAST) ? '0 : `CSX_DIV_W'(cnt_ff + 1'b1);
    end
  end

  assign tick = tick_ff;

endmodule : csx_clkdiv

// ---- csx_top.sv ----
// Continuous-transfer engine of a clocked synchronous serial port.
// Assumes a one-cycle register port on the same clock and an asynchronous
// serial peer whose clock and data pins are sampled by this clock.
//
// How it works
// - Length field zero in ctrl two gives eight-bit words.
// - Ctrl zero E3h/C3h/A3h: clock on, MSB first, continuous, tx-rx/tx/rx.
// - Direction bit zero means MSB first; polarity and phase 00 give type 1.
// - Transmit buffer write sets busy flag; in master mode it starts at once.
// - Master drives serial clock, shifts out and samples in on that clock.
// - Buffer moved into shift register raises transmit-enable request when the continue bit is set.
// - Each completed word with receive on fills buffer; raises receive-complete unless it overruns.
// - Word written before completion follows immediately without a gap.
// - Master transmit with no new word at completion stops clock, clears busy flag.
// - Slave, once armed, shifts out on the edges of the external clock.
// - Slave transmit continues only with a word written to the buffer before completion.
// - Slave transmit: full word of clocks with no new write clears busy.
// - Transmit-only mode raises receive-complete only when the continue bit is clear.
// - Receive-only: dummy read of receive buffer sets busy and arms reception.
// - Slave receive with continue and SCE bits set keeps receiving on each clock.
// - Continue bit cleared mid-word: finish word, interrupt, clear busy flag.
// - Word completed before buffer read overwrites; with continue bit set, sets overrun, raises error.
`include "csx_map.svh"

module csx_top (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire csx_pkg::csx_req_s req,
  output logic [7:0]             rd_data,
  // Serial pins
  input  wire logic              serial_clock_pin_in,
  output logic                   serial_clock_pin_out,
  output logic                   serial_clock_pin_oe_n,
  output logic                   serial_out_pin,
  input  wire logic              serial_in_pin,
  // Interrupt request pulses
  output logic                   transmit_enable_irq,
  output logic                   receive_complete_irq,
  output logic                   receive_error_irq
);

  localparam csx_pkg::csx_state_s RST_STATE = '{
    phase:     csx_pkg::CSX_IDLE,
    ctl0:      `CSX_RST_CTL0,
    ctl1:      `CSX_RST_CTL1,
    ctl2:      `CSX_RST_CTL2,
    tsf:       1'b0,
    ove:       1'b0,
    tx_buf:    `CSX_RST_BYTE,
    tx_full:   1'b0,
    rx_buf:    `CSX_RST_BYTE,
    rx_unread: 1'b0,
    sreg:      `CSX_RST_BYTE,
    cnt:       4'h0,
    sck:       1'b1,
    sck_oe_n:  1'b1,
    so:        1'b0,
    sck_prev:  1'b1,
    irq:       3'h0,
    rd_data:   `CSX_RST_BYTE
  };

  csx_pkg::csx_state_s state_ff;
  csx_pkg::csx_state_s nxt_state;

  logic [1:0] pin_sync;
  logic       sck_sync;
  logic       si_sync;
  logic       tick;
  logic       div_run;

  // Pins come from the peer's domain
  csx_sync #(
    .W (2)
  ) u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({serial_clock_pin_in, serial_in_pin}),
    .dout  (pin_sync)
  );

  assign sck_sync = pin_sync[1];
  assign si_sync  = pin_sync[0];

  // Half-period ticks of the internal shift clock
  csx_clkdiv u_div (
    .clock (clock),
    .rst   (rst),
    .run   (div_run),
    .tick  (tick)
  );

  // Decoded controls
  logic       pwr;
  logic       txe;
  logic       rxe;
  logic       lsb_first;
  logic       cont;
  logic       sce;
  logic       master;
  logic [3:0] len;
  logic [2:0] top_bit;

  always_comb begin
    pwr       = state_ff.ctl0[`CSX_C0_PWR];
    txe       = state_ff.ctl0[`CSX_C0_TXE];
    rxe       = state_ff.ctl0[`CSX_C0_RXE];
    lsb_first = state_ff.ctl0[`CSX_C0_DIR];
    cont      = state_ff.ctl0[`CSX_C0_CONT];
    sce       = state_ff.ctl0[`CSX_C0_SCE];
    master    = state_ff.ctl1[`CSX_C1_CKS_HI:`CSX_C1_CKS_LO] != `CSX_CKS_EXT;
    // Lengths above eight are clamped: the buffers are one byte wide
    if (state_ff.ctl2 == `CSX_LEN_ZERO || state_ff.ctl2 > `CSX_LEN_FULL) begin
      len = `CSX_LEN_FULL;
    end else begin
      len = state_ff.ctl2;
    end
    top_bit = 3'(len - 4'h1);
  end

  // Register port events the engine accepts; refusals have no port indication
  logic tx_wr_ok;
  logic rx_arm;
  logic ove_clr;

  always_comb begin
    // A full buffer refuses the write; single mode refuses it while busy
    tx_wr_ok = req.wr && (req.addr == `CSX_OFS_TXBUF) && pwr && txe
               && !state_ff.tx_full && (cont || !state_ff.tsf);
    // Dummy read arms only an idle receive-only unit
    rx_arm   = req.rd && (req.addr == `CSX_OFS_RXBUF) && pwr && rxe && !txe
               && !state_ff.tsf;
    // Writing zero to bit 0 clears; a one there leaves the flag alone
    ove_clr  = req.wr && (req.addr == `CSX_OFS_STATUS) && !req.wdata[`CSX_ST_OVE];
  end

  assign div_run = pwr && master && (state_ff.phase == csx_pkg::CSX_RUN);

  // Shift edges: internal ticks in master mode, synchronised pin edges in slave
  logic fall_ev;
  logic rise_ev;

  always_comb begin
    if (master) begin
      fall_ev = tick && state_ff.sck;
      rise_ev = tick && !state_ff.sck;
    end else begin
      fall_ev = state_ff.sck_prev && !sck_sync;
      rise_ev = !state_ff.sck_prev && sck_sync;
    end
  end

  // Bit that goes out first from a freshly loaded word
  function automatic logic first_bit(input logic [7:0] w, input logic lsb,
                                     input logic [2:0] tb);
    first_bit = lsb ? w[0] : w[tb];
  endfunction : first_bit

  logic [7:0] shifted;
  logic       done;

  always_comb begin
    nxt_state         = state_ff;
    nxt_state.irq     = 3'h0;
    nxt_state.sck_prev = sck_sync;
    nxt_state.sck_oe_n = !(pwr && master);
    shifted           = state_ff.sreg;
    done              = 1'b0;

    // Register reads; data stands one cycle after the strobe
    if (req.rd) begin
      case (req.addr)
        `CSX_OFS_CTL0:   nxt_state.rd_data = state_ff.ctl0;
        `CSX_OFS_CTL1:   nxt_state.rd_data = state_ff.ctl1;
        `CSX_OFS_CTL2:   nxt_state.rd_data = {4'h0, state_ff.ctl2};
        `CSX_OFS_STATUS: nxt_state.rd_data = {state_ff.tsf, 6'h00, state_ff.ove};
        `CSX_OFS_TXBUF:  nxt_state.rd_data = state_ff.tx_buf;
        `CSX_OFS_RXBUF:  nxt_state.rd_data = state_ff.rx_buf;
        default:         nxt_state.rd_data = 8'h00;
      endcase
      if (req.addr == `CSX_OFS_RXBUF) begin
        nxt_state.rx_unread = 1'b0;
        // Dummy read arms a receive-only transfer
        if (rx_arm) begin
          nxt_state.tsf = 1'b1;
        end
      end
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        `CSX_OFS_CTL0: nxt_state.ctl0 = req.wdata;
        `CSX_OFS_CTL1: nxt_state.ctl1 = req.wdata;
        `CSX_OFS_CTL2: nxt_state.ctl2 = req.wdata[`CSX_C2_LEN_HI:0];
        `CSX_OFS_STATUS: begin
          if (ove_clr) begin
            nxt_state.ove = 1'b0;
          end
        end
        `CSX_OFS_TXBUF: begin
          // Accepted writes only; refusals are decided in the event decode
          if (tx_wr_ok) begin
            nxt_state.tx_buf  = req.wdata;
            nxt_state.tx_full = 1'b1;
            nxt_state.tsf     = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    case (state_ff.phase)
      csx_pkg::CSX_IDLE: begin
        nxt_state.sck = 1'b1;
        nxt_state.cnt = 4'h0;
        if (pwr && state_ff.tsf) begin
          // Master starts at once; slave also enters run and waits there for the peer's clock
          nxt_state.phase = csx_pkg::CSX_RUN;
          if (txe && state_ff.tx_full) begin
            nxt_state.sreg    = state_ff.tx_buf;
            nxt_state.so      = first_bit(state_ff.tx_buf, lsb_first, top_bit);
            nxt_state.tx_full = 1'b0;
            nxt_state.irq.te  = cont;
          end else begin
            nxt_state.sreg = 8'h00;
          end
        end
      end

      csx_pkg::CSX_RUN: begin
        if (!pwr) begin
          nxt_state.phase = csx_pkg::CSX_IDLE;
          nxt_state.tsf   = 1'b0;
          nxt_state.sck   = 1'b1;
        end else begin
          // Type 1: data changes on the falling edge, sampled on the rising one
          if (fall_ev) begin
            if (master) begin
              nxt_state.sck = 1'b0;
            end
            nxt_state.so = lsb_first ? state_ff.sreg[0]
                                     : state_ff.sreg[top_bit];
          end
          if (rise_ev) begin
            if (master) begin
              nxt_state.sck = 1'b1;
            end
            if (lsb_first) begin
              shifted          = state_ff.sreg >> 1;
              shifted[top_bit] = si_sync;
            end else begin
              shifted = {state_ff.sreg[6:0], si_sync};
            end
            nxt_state.sreg = shifted;
            nxt_state.cnt  = 4'(state_ff.cnt + 4'h1);
            done           = (4'(state_ff.cnt + 4'h1) == len);
          end

          if (done) begin
            nxt_state.cnt = 4'h0;
            // Receive side of a finished word
            if (rxe) begin
              nxt_state.rx_buf    = shifted;
              nxt_state.rx_unread = 1'b1;
              if (state_ff.rx_unread && cont) begin
                // Previous word is lost: buffer is overwritten anyway
                nxt_state.ove    = 1'b1;
                nxt_state.irq.er = 1'b1;
              end else begin
                nxt_state.irq.rc = 1'b1;
              end
            end else if (!cont) begin
              nxt_state.irq.rc = 1'b1;
            end

            // Decide between continuing and stopping
            if (txe) begin
              // A write landing in this very cycle is still in time
              if (cont && nxt_state.tx_full) begin
                // Back-to-back word, no idle clock in between
                nxt_state.sreg    = nxt_state.tx_buf;
                // First bit leaves on the next falling edge; changing it here races the sampler
                nxt_state.tx_full = 1'b0;
                nxt_state.irq.te  = 1'b1;
              end else begin
                nxt_state.phase = csx_pkg::CSX_IDLE;
                nxt_state.tsf   = 1'b0;
              end
            end else begin
              // Receive only: the continue and SCE bits as seen at completion decide
              if (cont && sce) begin
                nxt_state.sreg = 8'h00;
              end else begin
                nxt_state.phase = csx_pkg::CSX_IDLE;
                nxt_state.tsf   = 1'b0;
              end
            end
          end
        end
      end

      default: begin
        nxt_state.phase = csx_pkg::CSX_IDLE;
      end
    endcase

    // Overrun is held until software writes zero; a new overrun wins over the clear
    if (state_ff.ove && !nxt_state.ove && nxt_state.irq.er) begin
      nxt_state.ove = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register
  assign rd_data               = state_ff.rd_data;
  assign serial_clock_pin_out  = state_ff.sck;
  assign serial_clock_pin_oe_n = state_ff.sck_oe_n;
  assign serial_out_pin        = state_ff.so;
  assign transmit_enable_irq   = state_ff.irq.te;
  assign receive_complete_irq  = state_ff.irq.rc;
  assign receive_error_irq     = state_ff.irq.er;

endmodule : csx_top

// ---- csx_top_properties.sv ----
// Concurrent checks on the serial engine's top-level ports.
// Assumes it is bound to csx_top; one clock domain, rst asynchronous high.
`include "csx_map.svh"

module csx_top_properties (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Register port
  input wire csx_pkg::csx_req_s req,
  input wire logic [7:0]        rd_data,
  // Serial pins
  input wire logic              serial_clock_pin_out,
  input wire logic              serial_clock_pin_oe_n,
  input wire logic              serial_out_pin,
  // Interrupt pulses
  input wire logic              transmit_enable_irq,
  input wire logic              receive_complete_irq,
  input wire logic              receive_error_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Data must sit still until the peer samples it on the rising edge
  sequence s_low_hold;
    (!serial_clock_pin_out && $stable(serial_out_pin)) [*3] ##1 serial_clock_pin_out;
  endsequence
  sequence s_high_hold;
    serial_clock_pin_out [*3];
  endsequence

  property p_low_half;
    $fell(serial_clock_pin_out) |=> s_low_hold;
  endproperty
  property p_high_half;
    $rose(serial_clock_pin_out) |=> s_high_hold;
  endproperty
  property p_fall_driven;
    $fell(serial_clock_pin_out) |-> !serial_clock_pin_oe_n;
  endproperty
  property p_te_pulse;
    transmit_enable_irq |=> !transmit_enable_irq;
  endproperty
  property p_rc_er_excl;
    !(receive_complete_irq && receive_error_irq);
  endproperty
  property p_word_gap;
    (receive_complete_irq || receive_error_irq) |=>
      !(receive_complete_irq || receive_error_irq) [*8];
  endproperty
  property p_rd_hold;
    !$past(req.rd) |-> $stable(rd_data);
  endproperty
  // Slave words may wait on the peer's clock, hence the wide window
  property p_te_cause;
    (req.wr && req.addr == `CSX_OFS_TXBUF) |-> ##[1:400] transmit_enable_irq;
  endproperty

  a_low_half: assert property (p_low_half) else $error("clock low phase wrong");
  a_high_half: assert property (p_high_half) else $error("clock high short");
  a_fall_driven: assert property (p_fall_driven) else $error("clock undriven");
  a_te_pulse: assert property (p_te_pulse) else $error("te not a pulse");
  a_rc_er_excl: assert property (p_rc_er_excl) else $error("rc with er");
  a_word_gap: assert property (p_word_gap) else $error("word ends too close");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_te_cause: assert property (p_te_cause) else $error("no te after write");
endmodule : csx_top_properties

// ---- csx_peer.sv ----
// Behavioural serial peer: feeds words on data-in, captures data-out.
// Assumes type 1 timing on the wire clock it is given.
module csx_peer (
  // Wire clock and device data
  input  wire logic pin_sck,
  input  wire logic dev_so,
  // Peer-driven lines
  output logic      ext_sck,
  output logic      peer_si
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] feed[$];
  logic [7:0] got[$];
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  int         nb;

  initial begin
    ext_sck = 1'b1; // Idles high outside frames
    peer_si = 1'b0;
    nb = 0;
  end
  // MSB leads; new bit on each falling edge
  always @(negedge pin_sck) begin
    if (nb == 0) sh_out = (feed.size() > 0) ? feed.pop_front() : 8'h00;
    peer_si <= sh_out[7];
    sh_out = {sh_out[6:0], 1'b0};
  end
  // Capture on rising edges
  always @(posedge pin_sck) begin
    sh_in = {sh_in[6:0], dev_so};
    nb = nb + 1;
    if (nb == 8) begin
      got.push_back(sh_in);
      nb = 0;
      peer_si <= #40 ~peer_si; // Released line flips, but only after the sampling edge
    end
  end
  // Slave frames; odd offset keeps phase unrelated to the system clock
  task automatic burst(input int n);
    #7;
    repeat (n * 8) begin
      #80 ext_sck = 1'b0;
      #80 ext_sck = 1'b1;
    end
  endtask : burst
endmodule : csx_peer

// ---- csx_top_tb_top.sv ----
// Self-checking bench for the serial engine with a peer on its pins.
// Assumes csx_top, csx_peer and the properties module are compiled first.
`include "csx_map.svh"

module csx_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock, rst, pin_sck, peer_sck, peer_si;
  logic              sck_out, sck_oe_n, so, te, rc, er;
  logic [7:0]        rd_data, v;
  logic [7:0]        sent[$], fed[$];
  csx_pkg::csx_req_s req;
  int                fail_count, checks_done, seed, n_te, n_rc, n_er;

  assign pin_sck = sck_oe_n ? peer_sck : sck_out;

  csx_top uut (.clock(clock), .rst(rst), .req(req), .rd_data(rd_data),
    .serial_clock_pin_in(pin_sck), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin(so), .serial_in_pin(peer_si),
    .transmit_enable_irq(te), .receive_complete_irq(rc), .receive_error_irq(er));
  csx_peer peer (.pin_sck(pin_sck), .dev_so(so), .ext_sck(peer_sck), .peer_si(peer_si));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    n_te += int'(te === 1'b1);
    n_rc += int'(rc === 1'b1);
    n_er += int'(er === 1'b1);
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req <= '{a, d, 1'b0, 1'b0};
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 v = rd_data;
  endtask : rd
  // Bounded wait on the te (k=0) or rc count
  task automatic await(input int k, input int n);
    int i;
    for (i = 0; i < 3000 && (k == 0 ? n_te : n_rc) < n; i++) @(posedge clock);
    if (i == 3000) begin
      fail_count++;
      summarize();
    end
  endtask : await
  task automatic idle;
    int i;
    for (i = 0; i < 200; i++) begin
      rd(`CSX_OFS_STATUS);
      if (v[`CSX_ST_TSF] === 1'b0) break;
    end
    if (i == 200) begin
      fail_count++;
      summarize();
    end
  endtask : idle
  // Mode 0 tx only, 1 read every word, 2 read only after the last word
  task automatic xfer(input int n, input int mode, input bit slv);
    int         t0, r0, e0;
    logic [7:0] w, p;
    t0 = n_te; r0 = n_rc; e0 = n_er;
    peer.nb = 0; peer.got.delete(); peer.feed.delete();
    sent.delete();
    fed.delete();
    for (int k = 0; k < n; k++) begin
      w = 8'($random(seed));
      p = 8'($random(seed));
      sent.push_back(w);
      fed.push_back(p);
      peer.feed.push_back(p);
      wr(`CSX_OFS_TXBUF, w);
      if (slv && k == 0) fork peer.burst(n); join_none
      await(0, t0 + k + 1);
      if (mode == 1 && k > 0) begin
        await(1, r0 + k);
        rd(`CSX_OFS_RXBUF);
        chk("rx", v, fed[k-1]);
      end
    end
    idle();
    repeat (4) @(posedge clock);
    chk("te", 8'(n_te - t0), 8'(n));
    for (int k = 0; k < n; k++) chk("peer", peer.got[k], sent[k]);
    chk("words", 8'(peer.got.size()), 8'(n));
    if (mode == 0) chk("rc", 8'(n_rc - r0), 8'h00);
    if (mode == 1) chk("rc", 8'(n_rc - r0), 8'(n));
    if (mode == 2) chk("er", 8'(n_er - e0), 8'(n - 1));
    if (mode == 2) begin
      rd(`CSX_OFS_STATUS);
      chk("ove", v, 8'h01);
      wr(`CSX_OFS_STATUS, 8'h00);
      rd(`CSX_OFS_STATUS);
      chk("ove", v, 8'h00);
    end
    if (mode != 0) begin
      rd(`CSX_OFS_RXBUF);
      chk("rx", v, fed[n-1]);
    end
  endtask : xfer
  task automatic rx_only(input bit slv);
    logic [7:0] p0, p1;
    int         r0;
    p0 = 8'($random(seed));
    p1 = 8'($random(seed));
    peer.nb = 0; peer.feed.delete();
    peer.feed.push_back(p0);
    peer.feed.push_back(p1);
    r0 = n_rc;
    wr(`CSX_OFS_CTL0, 8'ha3);
    rd(`CSX_OFS_RXBUF);
    if (slv) fork peer.burst(2); join_none
    await(1, r0 + 1);
    if (!slv) wr(`CSX_OFS_CTL0, 8'ha2);
    rd(`CSX_OFS_RXBUF);
    chk("rx", v, p0);
    await(1, r0 + 2);
    rd(`CSX_OFS_RXBUF);
    chk("rx", v, p1);
    if (!slv) idle();
  endtask : rx_only

  initial begin
    clock = 1'b0; rst = 1'b1; req = '0; seed = 15900;
    fail_count = 0; checks_done = 0; n_te = 0; n_rc = 0; n_er = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    rd(`CSX_OFS_STATUS);
    chk("status", v, 8'h00);
    rd(3'h6);
    chk("unmapped", v, 8'h00);
    wr(`CSX_OFS_CTL1, 8'h00);
    wr(`CSX_OFS_CTL2, 8'h00);
    wr(`CSX_OFS_CTL0, 8'he3);
    rd(`CSX_OFS_CTL0);
    chk("ctl0", v, 8'he3);
    xfer(3, 1, 1'b0);
    xfer(3, 2, 1'b0);
    wr(`CSX_OFS_CTL0, 8'hc3);
    xfer(2, 0, 1'b0);
    rx_only(1'b0);
    idle();
    wr(`CSX_OFS_CTL0, 8'h00);
    wr(`CSX_OFS_CTL1, 8'h07);
    wr(`CSX_OFS_CTL0, 8'hc3);
    xfer(2, 0, 1'b1);
    rx_only(1'b1);
    summarize();
  end
endmodule : csx_top_tb_top

bind csx_top csx_top_properties u_props (.clock(clock), .rst(rst), .req(req),
  .rd_data(rd_data), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .serial_out_pin(serial_out_pin),
  .transmit_enable_irq(transmit_enable_irq), .receive_complete_irq(receive_complete_irq),
  .receive_error_irq(receive_error_irq));
